// >>> rtl/access_line_tagging_agent.sv
// Discovery frame parser, filter, tag inserter and stripper with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "tag_agent_cfg.svh"
// What this block does
// - Type 8863 is discovery, 8864 is session
// - Version nibble must equal one
// - Type nibble must equal one
// - Code byte gives discovery packet kind
// - Session id then length of all tags
// - Tags are type, length, then data
// - End, service, server, vendor tag types
// - Host-unique, cookie, relay session tag types
// - Service, server and generic error tags
// - Inserted tag uses vendor type and length
// - Enterprise number leads the inserted data
// - Circuit sub-option one, remote sub-option two
// - Node identifier used only below 47 bytes
// - Without node identifier, six MAC bytes lead
// - Default circuit: node eth slot/port:vlan
// - Configured circuit string replaces default one
// - Remote id is MAC unless shorter string
// - Clients send PADI/PADR, servers PADO/PADS
// - Untrusted ports pass only PADI, PADR, PADT
// - Strip vendor tag from server replies
// - Strip only on trusted, strip-enabled port
// - Insert tag only into PADI and PADR
// - Act only when globally and port enabled
module access_line_tagging_agent
  import tag_agent_pkg::*;
#(
  parameter int DEPTH = 2048,
  parameter logic [31:0] ENTERPRISE = 32'h00000A5A // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_sop,
  output logic out_eop,
  input wire logic out_ready
);
  // ==================== State ====================
  typedef struct packed {
    agent_state_t state;
    logic in_rdy;
    logic [10:0] cnt, flen, tptr, rd, soff, slen;
    logic [15:0] etype, plen;
    logic [7:0] vt, code, tpos;
    logic walk, found, ins, strip, mod;
    logic [1:0] fpos;
    logic [31:0] crc;
    logic ov, osop, oeop;
    logic [7:0] od;
    logic [3:0] ctrl;
    logic [47:0] mac;
    logic [5:0] ani_len, cid_len, rid_len;
    logic [15:0] slot, drops;
    logic [23:0] port;
    logic [31:0] vlan, hrd;
    logic hwr;
    logic [8:0] hadr;
  } agent_reg_t;
  agent_reg_t s_r, s_nxt;
  logic [7:0] fmem [DEPTH]; // Stored frame
  logic [7:0] smem [192]; // Node, circuit, remote strings
  logic [31:0] crc_upd; // CRC after emitted byte
  logic [7:0] emit_b; // Byte being emitted
  logic fin, active, disc, drop_now; // Frame-end decision terms

  // ==================== Helpers ====================
  // Byte j of the switch MAC, most significant first
  function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [7:0] j);
    mac_byte = m[8'd47 - {j[4:0], 3'b000} -: 8];
  endfunction : mac_byte

  logic ani_ok, rid_ok; // Configured strings usable
  logic [7:0] node_n, cid_n, rid_n, tag_n; // Field lengths
  assign ani_ok = (s_r.ani_len != 6'd0) && (s_r.ani_len < `ANI_MAX);
  assign rid_ok = (s_r.rid_len != 6'd0) && (s_r.rid_len < `RID_MAX);
  assign node_n = ani_ok ? {2'b00, s_r.ani_len} : {2'b00, `MAC_BYTES};
  assign cid_n = (s_r.cid_len != 6'd0) ? {2'b00, s_r.cid_len} : node_n + `CID_SUFFIX;
  assign rid_n = rid_ok ? {2'b00, s_r.rid_len} : {2'b00, `MAC_BYTES};
  assign tag_n = `TAG_FIXED + cid_n + rid_n;

  // Circuit identifier byte j: override, or node + " eth " + slot/port:vlan
  function automatic logic [7:0] cid_byte(input agent_reg_t s, input logic [7:0] j,
                                          input logic [7:0] nn, input logic aok);
    logic [7:0] k;
    k = j - nn;
    if (s.cid_len != 6'd0) begin
      cid_byte = smem[`STR_CID + j];
    end else if (j < nn) begin
      cid_byte = aok ? smem[`STR_ANI + j] : mac_byte(s.mac, j);
    end else begin
      unique case (k)
        8'h00, 8'h04: cid_byte = 8'h20;
        8'h01: cid_byte = 8'h65;
        8'h02: cid_byte = 8'h74;
        8'h03: cid_byte = 8'h68;
        8'h05: cid_byte = s.slot[15:8];
        8'h06: cid_byte = s.slot[7:0];
        8'h07: cid_byte = 8'h2F;
        8'h08: cid_byte = s.port[23:16];
        8'h09: cid_byte = s.port[15:8];
        8'h0A: cid_byte = s.port[7:0];
        8'h0B: cid_byte = 8'h3A;
        8'h0C: cid_byte = s.vlan[31:24];
        8'h0D: cid_byte = s.vlan[23:16];
        8'h0E: cid_byte = s.vlan[15:8];
        default: cid_byte = s.vlan[7:0];
      endcase
    end
  endfunction : cid_byte

  // Inserted vendor tag byte k
  logic [7:0] tag_b; // Current tag byte
  logic [7:0] tk; // Offset inside remote part
  logic [15:0] tlen; // Tag data length
  always_comb begin
    tk = s_r.tpos - (8'd10 + cid_n);
    tlen = {8'h00, tag_n - 8'd4};
    if (s_r.tpos < 8'd4) begin
      tag_b = 8'((s_r.tpos[1] ? tlen : `TAG_VENDOR) >> (s_r.tpos[0] ? 0 : 8));
    end else if (s_r.tpos < 8'd8) begin
      tag_b = ENTERPRISE[8'd31 - {s_r.tpos[1:0], 3'b000} -: 8];
    end else if (s_r.tpos == 8'd8) begin
      tag_b = `SUB_CIRCUIT;
    end else if (s_r.tpos == 8'd9) begin
      tag_b = cid_n;
    end else if (s_r.tpos < 8'd10 + cid_n) begin
      tag_b = cid_byte(s_r, s_r.tpos - 8'd10, node_n, ani_ok);
    end else if (tk == 8'd0) begin
      tag_b = `SUB_REMOTE;
    end else if (tk == 8'd1) begin
      tag_b = rid_n;
    end else begin
      tag_b = rid_ok ? smem[`STR_RID + tk - 8'd2] : mac_byte(s_r.mac, tk - 8'd2);
    end
  end

  fcs_byte_update u_fcs (
    .crc_in(s_r.crc),
    .data(emit_b),
    .crc_out(crc_upd)
  );

  // ==================== Next-state logic ====================
  always_comb begin
    logic [10:0] rdx, last, nlen;
    logic [15:0] ttype, tl;
    logic okc;
    s_nxt = s_r;
    emit_b = 8'h00;
    fin = 1'b0;
    active = s_r.ctrl[`CTRL_GLOBAL] && s_r.ctrl[`CTRL_PORT];
    disc = (s_r.etype == `ETH_DISC);
    okc = (s_r.code == `CODE_PADI) || (s_r.code == `CODE_PADR)
          || (s_r.code == `CODE_PADT);
    drop_now = disc && active && ((s_r.vt != `VER_TYPE)
               || (!s_r.ctrl[`CTRL_TRUST] && !okc));
    rdx = (s_r.strip && s_r.rd == s_r.soff) ? s_r.rd + s_r.slen : s_r.rd;
    last = s_r.mod ? s_r.flen - `FCS_BYTES : s_r.flen;
    nlen = s_r.plen[10:0] + (s_r.ins ? {3'b000, tag_n} : 11'd0)
           - (s_r.strip ? s_r.slen : 11'd0);
    ttype = {fmem[s_r.tptr], fmem[s_r.tptr + 11'd1]};
    tl = {fmem[s_r.tptr + 11'd2], in_data};
    // Receive and parse
    if (s_r.state == ST_RECV && s_r.in_rdy && in_valid) begin
      s_nxt.cnt = in_sop ? 11'd1 : s_r.cnt + 11'd1;
      unique case (in_sop ? 11'd0 : s_r.cnt)
        `OFF_TYPE_HI: s_nxt.etype[15:8] = in_data;
        `OFF_TYPE_LO: s_nxt.etype[7:0] = in_data;
        `OFF_VT: s_nxt.vt = in_data;
        `OFF_CODE: s_nxt.code = in_data;
        `OFF_LEN_HI: s_nxt.plen[15:8] = in_data;
        `OFF_LEN_LO: begin
          s_nxt.plen[7:0] = in_data;
          s_nxt.walk = disc && ({s_r.plen[15:8], in_data} != 16'h0000);
          s_nxt.tptr = `OFF_TAGS;
        end
        default: ;
      endcase
      if (in_sop) begin
        s_nxt.found = 1'b0;
        s_nxt.walk = 1'b0;
      end else if (s_r.walk && s_r.cnt == s_r.tptr + 11'd3) begin
        // Tag header complete: type and length known
        // Every tag, the vendor one included, is skipped by its length
        s_nxt.tptr = s_r.tptr + 11'd4 + tl[10:0];
        if (ttype == `TAG_VENDOR && !s_r.found) begin
          s_nxt.found = 1'b1;
          s_nxt.soff = s_r.tptr;
          s_nxt.slen = 11'd4 + tl[10:0];
        end
        if (ttype == `TAG_END || s_nxt.tptr >= `OFF_TAGS + s_r.plen[10:0]) begin
          s_nxt.walk = 1'b0;
        end
      end
      if (in_eop) begin
        fin = 1'b1;
        s_nxt.flen = s_nxt.cnt;
        s_nxt.cnt = 11'd0;
        s_nxt.ins = disc && active && !drop_now && (s_r.vt == `VER_TYPE)
                    && ((s_r.code == `CODE_PADI) || (s_r.code == `CODE_PADR));
        s_nxt.strip = disc && active && !drop_now && s_r.ctrl[`CTRL_TRUST]
                      && s_r.ctrl[`CTRL_STRIP] && s_nxt.found
                      && ((s_r.code == `CODE_PADO) || (s_r.code == `CODE_PADS)
                          || (s_r.code == `CODE_PADT));
        s_nxt.mod = s_nxt.ins || s_nxt.strip;
        s_nxt.rd = 11'd0;
        s_nxt.tpos = 8'd0;
        s_nxt.fpos = 2'd0;
        s_nxt.crc = `CRC_INIT;
        if (drop_now) begin
          s_nxt.drops = s_r.drops + 16'h0001;
        end else begin
          s_nxt.state = s_nxt.mod ? ST_HEAD : ST_BODY;
        end
      end
    end
    // Transmit one byte whenever the output register is free
    if (out_ready) begin
      s_nxt.ov = 1'b0;
    end
    if (!s_r.ov || out_ready) begin
      s_nxt.osop = 1'b0;
      s_nxt.oeop = 1'b0;
      unique case (s_r.state)
        ST_HEAD: begin
          emit_b = (s_r.rd == `OFF_LEN_HI) ? {5'h00, nlen[10:8]} :
                   (s_r.rd == `OFF_LEN_LO) ? nlen[7:0] : fmem[s_r.rd];
          s_nxt.ov = 1'b1;
          s_nxt.osop = (s_r.rd == 11'd0);
          s_nxt.rd = s_r.rd + 11'd1;
          if (s_r.rd == `OFF_LEN_LO) begin
            s_nxt.state = s_r.ins ? ST_TAG : ST_BODY;
          end
        end
        ST_TAG: begin
          emit_b = tag_b;
          s_nxt.ov = 1'b1;
          s_nxt.tpos = s_r.tpos + 8'd1;
          if (s_r.tpos == tag_n - 8'd1) begin
            s_nxt.state = ST_BODY;
          end
        end
        ST_BODY: begin
          if (rdx >= last) begin
            // Edited frame: body done, append new FCS
            s_nxt.state = s_r.mod ? ST_FCS : ST_RECV;
          end else begin
            emit_b = fmem[rdx];
            s_nxt.ov = 1'b1;
            s_nxt.osop = (rdx == 11'd0);
            s_nxt.rd = rdx + 11'd1;
            if (!s_r.mod && rdx + 11'd1 == last) begin
              s_nxt.oeop = 1'b1;
              s_nxt.state = ST_RECV;
            end
          end
        end
        ST_FCS: begin
          emit_b = ~s_r.crc[{s_r.fpos, 3'b000} +: 8];
          s_nxt.ov = 1'b1;
          s_nxt.fpos = s_r.fpos + 2'd1;
          if (s_r.fpos == 2'd3) begin
            s_nxt.oeop = 1'b1;
            s_nxt.state = ST_RECV;
          end
        end
        default: ;
      endcase
      if (s_r.mod && (s_r.state == ST_HEAD || s_r.state == ST_TAG
                      || (s_r.state == ST_BODY && rdx < last))) begin
        s_nxt.crc = crc_upd;
      end
      if (s_nxt.ov && s_r.state != ST_RECV) begin
        s_nxt.od = emit_b;
      end
    end
    s_nxt.in_rdy = (s_nxt.state == ST_RECV);
    // AHB-Lite write data phase
    if (s_r.hwr) begin
      unique case (s_r.hadr)
        `REG_CTRL: s_nxt.ctrl = hwdata[3:0];
        `REG_MAC_LO: s_nxt.mac[31:0] = hwdata;
        `REG_MAC_HI: s_nxt.mac[47:32] = hwdata[15:0];
        `REG_ANI_LEN: s_nxt.ani_len = hwdata[5:0];
        `REG_CID_LEN: s_nxt.cid_len = hwdata[5:0];
        `REG_RID_LEN: s_nxt.rid_len = hwdata[5:0];
        `REG_SLOT: s_nxt.slot = hwdata[15:0];
        `REG_PORT: s_nxt.port = hwdata[23:0];
        `REG_VLAN: s_nxt.vlan = hwdata;
        default: ;
      endcase
    end
    // AHB-Lite address phase: zero wait states
    s_nxt.hwr = hsel && htrans[1] && hready && hwrite;
    s_nxt.hadr = haddr[8:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[8:0])
        `REG_CTRL: s_nxt.hrd = {28'h0000000, s_r.ctrl};
        `REG_STATUS: s_nxt.hrd = {s_r.drops, 7'h00, !s_r.in_rdy, s_r.code};
        `REG_MAC_LO: s_nxt.hrd = s_r.mac[31:0];
        `REG_MAC_HI: s_nxt.hrd = {16'h0000, s_r.mac[47:32]};
        `REG_ANI_LEN: s_nxt.hrd = {26'h0000000, s_r.ani_len};
        `REG_CID_LEN: s_nxt.hrd = {26'h0000000, s_r.cid_len};
        `REG_RID_LEN: s_nxt.hrd = {26'h0000000, s_r.rid_len};
        `REG_SLOT: s_nxt.hrd = {16'h0000, s_r.slot};
        `REG_PORT: s_nxt.hrd = {8'h00, s_r.port};
        `REG_VLAN: s_nxt.hrd = s_r.vlan;
        default: s_nxt.hrd = 32'h00000000;
      endcase
    end
  end

  // ==================== Registers ====================
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.state <= ST_RECV;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Frame store and string store
  always_ff @(posedge clock) begin
    if (s_r.state == ST_RECV && s_r.in_rdy && in_valid) begin
      fmem[in_sop ? 11'd0 : s_r.cnt] <= in_data;
    end
    if (s_r.hwr && s_r.hadr >= `STR_BASE && s_r.hadr <= `STR_LAST) begin
      for (int b = 0; b < 4; b++) begin
        smem[{s_r.hadr[7:2], 2'(b)}] <= hwdata[8 * b +: 8];
      end
    end
  end

  assign hreadyout = 1'b1 | s_r.hwr; // Always ready
  assign hresp = 1'b0;
  assign hrdata = s_r.hrd;
  assign in_ready = s_r.in_rdy;
  assign out_valid = s_r.ov;
  assign out_data = s_r.od;
  assign out_sop = s_r.osop;
  assign out_eop = s_r.oeop;

  // ==================== Checks ====================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_edit_disc: assert property (s_r.state == ST_HEAD |-> s_r.etype == `ETH_DISC)
    else $error("edited frame is not discovery");
  chk_ins_code: assert property (fin && s_nxt.ins |-> s_r.code == `CODE_PADI
    || s_r.code == `CODE_PADR) else $error("tag inserted into wrong code");
  chk_ins_enable: assert property (fin && s_nxt.mod |-> active)
    else $error("edit while agent disabled");
  chk_strip_trust: assert property (fin && s_nxt.strip |-> s_r.ctrl[`CTRL_TRUST])
    else $error("strip on untrusted port");
  chk_ver_type: assert property (fin && s_nxt.ins |-> s_r.vt == `VER_TYPE)
    else $error("insert with bad version or type");
  chk_tag_type: assert property (s_r.state == ST_TAG && s_r.tpos == 8'd1 &&
    (!s_r.ov || out_ready) |=> s_r.od == 8'h05 && s_r.ov) else $error("bad tag type");
  chk_ent_num: assert property (s_r.state == ST_TAG && s_r.tpos == 8'd4 &&
    (!s_r.ov || out_ready) |=> s_r.od == ENTERPRISE[31:24]) else $error("bad enterprise");
  chk_untrust_drop: assert property (fin && drop_now |=> s_r.state == ST_RECV)
    else $error("filtered frame forwarded");
  chk_fcs_end: assert property (s_r.state == ST_FCS && s_r.fpos == 2'd3 &&
    (!s_r.ov || out_ready) |=> s_r.oeop ##1 s_r.state == ST_RECV)
    else $error("fcs not closing frame");
  chk_pass_plain: assert property (fin && !disc |=> s_r.state == ST_BODY && !s_r.mod)
    else $error("non-discovery frame edited");
  cov_insert: cover property (fin && s_nxt.ins ##[1:300] s_r.oeop);
  cov_strip: cover property (fin && s_nxt.strip);
  cov_drop: cover property (fin && drop_now);
  cov_pass: cover property (fin && s_r.etype == `ETH_SESS);
endmodule : access_line_tagging_agent

// >>> common/tag_agent_cfg.svh
// Constants for the discovery tag agent: offsets, codes, field positions
`ifndef TAG_AGENT_CFG_SVH
`define TAG_AGENT_CFG_SVH
// ==================== Register byte offsets ====================
`define REG_CTRL 9'h000
`define REG_STATUS 9'h004
`define REG_MAC_LO 9'h008
`define REG_MAC_HI 9'h00C
`define REG_ANI_LEN 9'h010
`define REG_CID_LEN 9'h014
`define REG_RID_LEN 9'h018
`define REG_SLOT 9'h01C
`define REG_PORT 9'h020
`define REG_VLAN 9'h024
`define STR_BASE 9'h100
`define STR_LAST 9'h1BC
// ==================== Control bits ====================
`define CTRL_GLOBAL 0
`define CTRL_PORT 1
`define CTRL_TRUST 2
`define CTRL_STRIP 3
// ==================== String memory regions ====================
`define STR_ANI 8'h00
`define STR_CID 8'h40
`define STR_RID 8'h80
`define ANI_MAX 6'd47
`define RID_MAX 6'd63
`define MAC_BYTES 6'd6
`define CID_SUFFIX 8'd16
// ==================== Frame layout ====================
`define ETH_DISC 16'h8863
`define ETH_SESS 16'h8864
`define OFF_TYPE_HI 11'd12
`define OFF_TYPE_LO 11'd13
`define OFF_VT 11'd14
`define OFF_CODE 11'd15
`define OFF_LEN_HI 11'd18
`define OFF_LEN_LO 11'd19
`define OFF_TAGS 11'd20
`define FCS_BYTES 11'd4
`define VER_TYPE 8'h11
// ==================== Codes and tag types ====================
`define CODE_PADI 8'h09
`define CODE_PADO 8'h07
`define CODE_PADR 8'h19
`define CODE_PADS 8'h65
`define CODE_PADT 8'hA7
`define TAG_END 16'h0000
`define TAG_SVC_NAME 16'h0101
`define TAG_SRV_NAME 16'h0102
`define TAG_HOST_UNIQ 16'h0103
`define TAG_COOKIE 16'h0104
`define TAG_VENDOR 16'h0105
`define TAG_RELAY 16'h0110
`define TAG_SVC_ERR 16'h0201
`define TAG_SRV_ERR 16'h0202
`define TAG_GEN_ERR 16'h0203
`define SUB_CIRCUIT 8'h01
`define SUB_REMOTE 8'h02
`define TAG_FIXED 8'd12
`define CRC_INIT 32'hFFFFFFFF
`endif

// >>> common/tag_agent_pkg.sv
// Types shared by the discovery tag agent
package tag_agent_pkg;
  // Frame engine states, one-hot
  typedef enum logic [4:0] {
    ST_RECV = 5'b00001,
    ST_HEAD = 5'b00010,
    ST_TAG = 5'b00100,
    ST_BODY = 5'b01000,
    ST_FCS = 5'b10000
  } agent_state_t;
endpackage : tag_agent_pkg

// >>> rtl/fcs_byte_update.sv
// One byte step of the reflected Ethernet CRC-32
`timescale 1ns/10ps
module fcs_byte_update (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  // ==================== Bitwise step ====================
  // Eight LSB-first shifts with the reflected polynomial
  always_comb begin
    logic [31:0] c;
    c = crc_in ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    crc_out = c;
  end
endmodule : fcs_byte_update

// >>> test/eth_port_sink.sv
// Egress port model that takes frame bytes, promptly or with stalls
`timescale 1ns/10ps
module eth_port_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  output logic out_ready
);
  integer seed = 32'h364f0e62; // Stall pattern seed
  // ==================== Ready generation ====================
  // Always ready when prompt, about one cycle in three when slow
  always @(posedge clock) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !slow || ($random(seed) % 3 == 0);
    end
  end
endmodule : eth_port_sink

// >>> test/tb.sv
// Self-checking bench for the discovery tag agent
`timescale 1ns/10ps
`include "tag_agent_cfg.svh"
module tb;
  typedef logic [7:0] bq_t [$];
  localparam logic [31:0] ENT = 32'h0000C3A5; // Arbitrary enterprise number
  logic clock = 1'b0; // Bench clock
  logic rst = 1'b1; // Synchronous reset
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire hready; // Single slave, so its ready is the bus ready
  logic hresp;
  logic [31:0] hrdata;
  logic in_valid = 1'b0;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic in_ready;
  logic out_valid;
  logic out_sop;
  logic out_eop;
  logic out_ready;
  logic [7:0] out_data;
  logic slow = 1'b0; // Egress stall mode
  logic [9:0] exp_q [$]; // Expected {sop, eop, data}
  bq_t rid; // Expected remote identifier
  bq_t cid; // Expected circuit identifier
  int error_cnt = 0;
  int checks = 0;
  integer seed = 32'h364f0e62;
  logic [7:0] cd [5] = '{8'h09, 8'h07, 8'h19, 8'h65, 8'hA7};
  int act_u [5] = '{2, 1, 2, 1, 0}; // Untrusted outcome per code
  always #12.5 clock = ~clock;
  access_line_tagging_agent #(.ENTERPRISE(ENT)) access_line_tagging_agent_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_sop(out_sop),
    .out_eop(out_eop), .out_ready(out_ready));
  eth_port_sink eth_port_sink_inst (
    .clock(clock), .rst(rst), .slow(slow), .out_ready(out_ready));
  // ==================== Helpers ====================
  // Verdict and end of run
  task end_of_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // Counted comparison
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Reflected CRC-32 of a byte queue, low byte first
  function automatic bq_t crc(input bq_t b);
    logic [31:0] c;
    c = `CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
      end
    end
    c = ~c;
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : crc
  // One AHB-Lite single word transfer
  task automatic ahb(input logic wr, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {23'h0, a};
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : ~d;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 100);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 100) begin
      chk("bus_wait", 32'h0, 32'(n));
      end_of_test();
    end
  endtask : ahb
  // Ingress byte stream of one frame
  task automatic send(input bq_t f);
    int i;
    int n;
    i = 0;
    n = 0;
    in_valid <= 1'b1;
    in_sop <= 1'b1;
    in_data <= f[0];
    while (i < f.size() && n < 5000) begin
      @(posedge clock);
      n++;
      if (in_ready === 1'b1) begin
        i++;
        in_sop <= 1'b0;
        in_eop <= (i == f.size() - 1);
        if (i < f.size()) in_data <= f[i];
      end
    end
    in_valid <= 1'b0;
    in_data <= ~f[f.size() - 1];
    if (n >= 5000) begin
      chk("ingress_wait", 32'h0, 32'(n));
      end_of_test();
    end
  endtask : send
  // Build a frame, note its expected egress, send it and drain
  // act: 0 unchanged, 1 dropped, 2 tag inserted, 3 tag stripped
  task automatic frame(input logic [15:0] et, input logic [7:0] vt,
                       input logic [7:0] code, input bit vtag, input int act);
    bq_t b;
    bq_t e;
    bq_t ins;
    logic [15:0] len;
    int tl;
    int n;
    b = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h01, et[15:8], et[7:0], vt, code, 8'($random(seed)), 8'($random(seed))};
    len = vtag ? 16'd12 : 16'd4;
    b = {b, len[15:8], len[7:0]};
    if (vtag) b = {b, 8'h01, 8'h05, 8'h00, 8'h04, 8'hDE, 8'hAD, 8'hBE, 8'hEF};
    b = {b, 8'h01, 8'h01, 8'h00, 8'h00};
    e = b;
    tl = 8 + cid.size() + rid.size();
    ins = {8'h01, 8'h05, 8'h00, 8'(tl), ENT[31:24], ENT[23:16], ENT[15:8], ENT[7:0],
           8'h01, 8'(cid.size()), cid, 8'h02, 8'(rid.size()), rid};
    if (act == 2) begin
      len = len + 16'(tl + 4);
      e = {b[0:17], len[15:8], len[7:0], ins, b[20:$]};
    end else if (act == 3) begin
      len = len - 16'd8;
      e = {b[0:17], len[15:8], len[7:0], b[28:$]};
    end
    e = {e, crc(e)};
    b = {b, crc(b)};
    if (act != 1) begin
      foreach (e[i]) exp_q.push_back({i == 0, i == e.size() - 1, e[i]});
    end
    send(b);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (exp_q.size() != 0 && n < 4000);
    if (n >= 4000) begin
      chk("drain_wait", 32'h0, 32'(exp_q.size()));
      end_of_test();
    end
  endtask : frame
  // ==================== Egress monitor ====================
  // Each accepted byte is compared with the oldest note
  always @(posedge clock) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare_byte", 32'h0, {22'h3FFFFF, out_sop, out_eop, out_data});
      end else begin
        chk("out_byte", {22'h0, exp_q.pop_front()}, {22'h0, out_sop, out_eop, out_data});
      end
    end
  end
  // ==================== Main sequence ====================
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    ahb(1'b1, `REG_MAC_LO, 32'h0C0D0E0F, q);
    ahb(1'b1, `REG_MAC_HI, 32'h00000A0B, q);
    ahb(1'b1, `REG_CID_LEN, 32'h00000004, q);
    ahb(1'b1, `STR_BASE + 9'h040, 32'h61616161, q);
    ahb(1'b1, `REG_RID_LEN, 32'h00000003, q);
    ahb(1'b1, `STR_BASE + 9'h080, 32'h007A7978, q);
    ahb(1'b0, `REG_MAC_LO, 32'h0, q);
    chk("mac_lo", 32'h0C0D0E0F, q);
    ahb(1'b0, 9'h028, 32'h0, q);
    chk("unmapped", 32'h0, q);
    ahb(1'b1, `REG_CTRL, 32'h00000003, q);
    rid = {8'h78, 8'h79, 8'h7A};
    cid = {8'h61, 8'h61, 8'h61, 8'h61};
    slow <= 1'b1;
    frame(16'h0800, 8'h45, 8'h00, 1'b1, 0);
    frame(`ETH_SESS, 8'h11, `CODE_PADO, 1'b1, 0);
    for (int k = 0; k < 5; k++) frame(`ETH_DISC, 8'h11, cd[k], 1'b0, act_u[k]);
    frame(`ETH_DISC, 8'h21, `CODE_PADI, 1'b0, 1);
    frame(`ETH_DISC, 8'h12, `CODE_PADI, 1'b0, 1);
    ahb(1'b0, `REG_STATUS, 32'h0, q);
    chk("drop_count", 32'h4, {16'h0, q[31:16]});
    chk("status_low", 32'h00000009, {23'h0, q[8:0]});
    ahb(1'b1, `REG_RID_LEN, 32'd63, q);
    rid = {8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
    frame(`ETH_DISC, 8'h11, `CODE_PADR, 1'b0, 2);
    ahb(1'b1, `REG_CTRL, 32'h0000000F, q);
    frame(`ETH_DISC, 8'h11, `CODE_PADS, 1'b1, 3);
    frame(`ETH_DISC, 8'h11, `CODE_PADO, 1'b1, 3);
    frame(`ETH_DISC, 8'h11, `CODE_PADI, 1'b0, 2);
    ahb(1'b1, `REG_CTRL, 32'h00000007, q);
    frame(`ETH_DISC, 8'h11, `CODE_PADO, 1'b1, 0);
    ahb(1'b1, `REG_CTRL, 32'h0000000B, q);
    frame(`ETH_DISC, 8'h11, `CODE_PADT, 1'b1, 0);
    ahb(1'b1, `REG_CTRL, 32'h00000001, q);
    frame(`ETH_DISC, 8'h11, `CODE_PADI, 1'b0, 0);
    ahb(1'b1, `REG_CTRL, 32'h00000002, q);
    frame(`ETH_DISC, 8'h11, `CODE_PADO, 1'b0, 0);
    // Default circuit identifier, first led by the MAC, then by the node string
    ahb(1'b1, `REG_CTRL, 32'h00000003, q);
    ahb(1'b1, `REG_CID_LEN, 32'h00000000, q);
    ahb(1'b1, `REG_SLOT, 32'h00003031, q);
    ahb(1'b1, `REG_PORT, 32'h00303032, q);
    ahb(1'b1, `REG_VLAN, 32'h30303031, q);
    ahb(1'b1, `REG_ANI_LEN, 32'h0000002F, q);
    cid = {8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h20, 8'h65, 8'h74, 8'h68, 8'h20,
           8'h30, 8'h31, 8'h2F, 8'h30, 8'h30, 8'h32, 8'h3A, 8'h30, 8'h30, 8'h30, 8'h31};
    frame(`ETH_DISC, 8'h11, `CODE_PADI, 1'b0, 2);
    ahb(1'b1, `STR_BASE, 32'h64636261, q);
    ahb(1'b1, `REG_ANI_LEN, 32'h00000004, q);
    cid = {8'h61, 8'h62, 8'h63, 8'h64, cid[6:$]};
    frame(`ETH_DISC, 8'h11, `CODE_PADR, 1'b0, 2);
    repeat (20) @(posedge clock);
    chk("leftover", 32'h0, 32'(exp_q.size()));
    end_of_test();
  end
endmodule : tb
